// ### dv/djkff_drv.sv
// Far-side logic that makes low pulses on each cell clock pin
`timescale 1ns/1ns
module djkff_drv (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [1:0] i_fall,
    output logic      [1:0] o_cell_clk
);
    for (genvar c = 0; c < 2; c++) begin : g_c
        logic [2:0] n;
        // Low for four cycles, well above the shortest pulse the block sees
        always_ff @(posedge i_clk or negedge i_rst_b)
            if (!i_rst_b) n <= 3'h0;
            else if (i_fall[c]) n <= 3'h4;
            else if (n != 3'h0) n <= n - 3'h1;
        assign o_cell_clk[c] = (n == 3'h0);
    end
endmodule : djkff_drv

// ### dv/djkff_top_tb_top.sv
// Self-checking bench for the dual flip-flop block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t output mismatch", $time); end end
module djkff_top_tb_top;
    logic       i_clk, i_rst_b;
    logic [1:0] j, k, pre_n, clear_n, fall, cclk, q, q_b, eq;
    int         n_errors = 0, n_tests = 0, cyc = 0;
    djkff_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cell_clk(cclk), .i_set_data(j),
        .i_rst_data(k), .i_async_preset_n(pre_n), .i_async_clear_n(clear_n), .o_q(q),
        .o_q_b(q_b));
    djkff_drv drv (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_fall(fall), .o_cell_clk(cclk));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    function automatic logic nxt(logic s, logic a, logic b);
        return (a & b) ? ~s : a ? 1'b1 : b ? 1'b0 : s;
    endfunction : nxt
    task automatic wt(int n);
        repeat (n) @(posedge i_clk);
    endtask : wt
    task automatic chk();
        // Outputs are read half a cycle away from the edge that may move them
        @(negedge i_clk);
        for (int c = 0; c < 2; c++) begin
            `CHK(q[c], eq[c])
            `CHK(q_b[c], ~eq[c])
        end
    endtask : chk
    task pulse(int c, logic a, logic b);
        @(posedge i_clk);
        j[c] <= a;
        k[c] <= b;
        wt(3);
        fall[c] <= 1'b1;
        @(posedge i_clk);
        fall[c] <= 1'b0;
        if (pre_n[c] & clear_n[c]) eq[c] = nxt(eq[c], a, b);
        wt(10);
        chk();
    endtask : pulse
    task ctl(int c, logic p, logic l);
        @(posedge i_clk);
        pre_n[c] <= p;
        clear_n[c] <= l;
        wt(6);
    endtask : ctl
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    initial begin
        i_rst_b = 1'b0; j = 2'h0; k = 2'h0; fall = 2'h0; eq = 2'h0;
        pre_n = 2'h3;
        clear_n = 2'h3;
        void'($urandom(12));
        wt(8);
        i_rst_b <= 1'b1;
        wt(4);
        chk();
        for (int i = 0; i < 4; i++) pulse(i % 2, 1'(i >> 1), 1'(i));
        pulse(0, 1'b1, 1'b1);
        for (int i = 0; i < 40; i++) pulse(int'($urandom % 2), 1'($urandom), 1'($urandom));
        $display("test capture done");
        ctl(1, 1'b0, 1'b1); eq[1] = 1'b1; chk();
        ctl(1, 1'b1, 1'b0); eq[1] = 1'b0; chk();
        pulse(1, 1'b1, 1'b1);
        ctl(1, 1'b0, 1'b0);
        @(negedge i_clk);
        `CHK({q[1], q_b[1]}, 2'h3)
        ctl(1, 1'b1, 1'b0); chk();
        ctl(1, 1'b1, 1'b1); chk();
        $display("test overrides done");
        @(posedge i_clk);
        j <= ~j;
        k <= ~k;
        wt(8);
        chk();
        $display("test idle data done");
        close_out();
    end
endmodule : djkff_top_tb_top

// ### hw/djkff_cell.sv
// One input cell: two flip-flops that bring a pin into the clock domain
`timescale 1ns/1ns
module djkff_cell #(
    parameter logic RST_VAL = 1'h0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_level
);
    djkff_pkg::djkff_sync_s r;
    djkff_pkg::djkff_sync_s next_r;

    always_comb begin
        next_r         = r;
        next_r.stage_a = i_pin;
        next_r.stage_b = r.stage_a;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '{stage_a: RST_VAL, stage_b: RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    // Only the second stage leaves the cell; the first may still be settling
    assign o_level = r.stage_b;
endmodule : djkff_cell

// ### hw/djkff_map.svh
// Constants for the dual negative-edge toggle flip-flop block
`ifndef DJKFF_MAP_SVH
`define DJKFF_MAP_SVH
`define DJKFF_CELLS      2
`define DJKFF_RST_STATE  1'h0
`define DJKFF_CLK_RST    1'h0
`define DJKFF_DATA_RST   1'h0
`define DJKFF_CTRL_RST   1'h1
`endif

// ### hw/djkff_pkg.sv
// Types for the dual negative-edge toggle flip-flop block
package djkff_pkg;
    typedef enum logic [2:0] {
        DJKFF_RUN    = 3'h1,
        DJKFF_FORCE  = 3'h2,
        DJKFF_BOTH   = 3'h4
    } djkff_mode_e;
    typedef struct packed {
        logic        stage_a;
        logic        stage_b;
    } djkff_sync_s;
    typedef struct packed {
        logic        clk_prev;
        logic        state;
        logic        q;
        logic        q_b;
    } djkff_cell_s;
endpackage : djkff_pkg

// ### hw/djkff_top.sv
// Top of the dual negative-edge toggle flip-flop block
`timescale 1ns/1ns
`include "djkff_map.svh"
// How it works
// - Two independent cells, each with own clock, data, controls and outputs.
// - Preset low alone forces true high; clear low alone forces it low.
// - Both controls low drive both outputs high, only while both stay low.
// - Clock captures happen only while preset and clear are both high.
// - Falling edge: both low hold, set alone sets, reset alone clears.
// - Both data inputs high at a falling edge invert the state.
// - Data changes away from a falling edge leave outputs unchanged.
module djkff_top #(
    parameter int CELLS = `DJKFF_CELLS
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic [CELLS-1:0] i_cell_clk,
    input  wire logic [CELLS-1:0] i_set_data,
    input  wire logic [CELLS-1:0] i_rst_data,
    input  wire logic [CELLS-1:0] i_async_preset_n,
    input  wire logic [CELLS-1:0] i_async_clear_n,
    output logic      [CELLS-1:0] o_q,
    output logic      [CELLS-1:0] o_q_b
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (CELLS < 1) begin : g_bad
        $error("CELLS must be at least one");
    end

    // ----------------------------------------
    // State and wires
    // ----------------------------------------
    localparam djkff_pkg::djkff_cell_s CELL_RST = '{
        clk_prev: `DJKFF_CLK_RST,
        state:    `DJKFF_RST_STATE,
        q:        `DJKFF_RST_STATE,
        q_b:      ~`DJKFF_RST_STATE
    };

    djkff_pkg::djkff_cell_s [CELLS-1:0] r;
    djkff_pkg::djkff_cell_s [CELLS-1:0] next_r;
    djkff_pkg::djkff_mode_e             mode [CELLS];
    logic                   [CELLS-1:0] clk_lvl;
    logic                   [CELLS-1:0] set_lvl;
    logic                   [CELLS-1:0] rst_lvl;
    logic                   [CELLS-1:0] pre_lvl;
    logic                   [CELLS-1:0] clear_lvl;
    logic                   [CELLS-1:0] fall;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Every pin passes two flip-flops before any logic reads it
    for (genvar g = 0; g < CELLS; g++) begin : g_sync
        djkff_cell #(
            .RST_VAL (`DJKFF_CLK_RST)
        ) u_clk (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_pin   (i_cell_clk[g]),
            .o_level (clk_lvl[g])
        );

        djkff_cell #(
            .RST_VAL (`DJKFF_DATA_RST)
        ) u_set (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_pin   (i_set_data[g]),
            .o_level (set_lvl[g])
        );

        djkff_cell #(
            .RST_VAL (`DJKFF_DATA_RST)
        ) u_rst (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_pin   (i_rst_data[g]),
            .o_level (rst_lvl[g])
        );

        djkff_cell #(
            .RST_VAL (`DJKFF_CTRL_RST)
        ) u_pre (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_pin   (i_async_preset_n[g]),
            .o_level (pre_lvl[g])
        );

        djkff_cell #(
            .RST_VAL (`DJKFF_CTRL_RST)
        ) u_clear (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_pin   (i_async_clear_n[g]),
            .o_level (clear_lvl[g])
        );
    end

    // ----------------------------------------
    // Cell logic
    // ----------------------------------------
    always_comb begin
        next_r = r;
        fall   = '0;
        for (int c = 0; c < CELLS; c++) begin
            mode[c] = djkff_pkg::DJKFF_RUN;
        end
        for (int c = 0; c < CELLS; c++) begin
            next_r[c].clk_prev = clk_lvl[c];
            // A fall is one sampled high level followed by one sampled low level
            fall[c] = r[c].clk_prev & ~clk_lvl[c];
            if (!pre_lvl[c] && !clear_lvl[c]) begin
                mode[c] = djkff_pkg::DJKFF_BOTH;
            end else if (!pre_lvl[c] || !clear_lvl[c]) begin
                mode[c] = djkff_pkg::DJKFF_FORCE;
            end else begin
                mode[c] = djkff_pkg::DJKFF_RUN;
            end
            case (mode[c])
                djkff_pkg::DJKFF_BOTH: begin
                    // State left high, so a joint release settles as preset
                    next_r[c].state = 1'h1;
                    next_r[c].q     = 1'h1;
                    next_r[c].q_b   = 1'h1;
                end
                djkff_pkg::DJKFF_FORCE: begin
                    next_r[c].state = ~pre_lvl[c];
                    next_r[c].q     = ~pre_lvl[c];
                    next_r[c].q_b   = pre_lvl[c];
                end
                djkff_pkg::DJKFF_RUN: begin
                    if (fall[c]) begin
                        case ({set_lvl[c], rst_lvl[c]})
                            2'h1:    next_r[c].state = 1'h0;
                            2'h2:    next_r[c].state = 1'h1;
                            2'h3:    next_r[c].state = ~r[c].state;
                            default: next_r[c].state = r[c].state;
                        endcase
                    end
                    next_r[c].q   = next_r[c].state;
                    next_r[c].q_b = ~next_r[c].state;
                end
                default: begin
                    next_r[c].q   = r[c].state;
                    next_r[c].q_b = ~r[c].state;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= {CELLS{CELL_RST}};
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    for (genvar g = 0; g < CELLS; g++) begin : g_out
        assign o_q[g]   = r[g].q;
        assign o_q_b[g] = r[g].q_b;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    for (genvar g = 0; g < CELLS; g++) begin : g_chk
        complement_ok_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] || clear_lvl[g]) |=> (o_q[g] != o_q_b[g]))
            else $error("complement output not inverse of true output");

        both_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (!pre_lvl[g] && !clear_lvl[g]) |=> (o_q[g] && o_q_b[g]))
            else $error("both controls low did not drive both outputs high");

        preset_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (!pre_lvl[g] && clear_lvl[g]) |=> (o_q[g] && !o_q_b[g]))
            else $error("preset did not force true output high");

        clear_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] && !clear_lvl[g]) |=> (!o_q[g] && o_q_b[g]))
            else $error("clear did not force true output low");

        no_edge_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] && clear_lvl[g] && !fall[g] && o_q[g] != o_q_b[g]) |=> $stable(o_q[g]))
            else $error("output moved without a falling clock edge");

        toggle_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] && clear_lvl[g] && fall[g] && set_lvl[g] && rst_lvl[g]
             && o_q[g] != o_q_b[g]) |=> (o_q[g] != $past(o_q[g])))
            else $error("toggle did not invert the state");

        set_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] && clear_lvl[g] && fall[g] && set_lvl[g] && !rst_lvl[g])
            |=> o_q[g])
            else $error("set input did not set the state");

        reset_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (pre_lvl[g] && clear_lvl[g] && fall[g] && !set_lvl[g] && rst_lvl[g])
            |=> !o_q[g])
            else $error("reset input did not clear the state");

        async_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (!pre_lvl[g] && clear_lvl[g] && fall[g] && rst_lvl[g]) |=> o_q[g])
            else $error("clock edge captured while preset asserted");

        // Pin to output: a control held for three edges has reached the outputs
        preset_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (!i_async_preset_n[g] && i_async_clear_n[g]) [*3] |=> (o_q[g] && !o_q_b[g]))
            else $error("preset pin did not reach the outputs in time");

        clear_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (i_async_preset_n[g] && !i_async_clear_n[g]) [*3] |=> (!o_q[g] && o_q_b[g]))
            else $error("clear pin did not reach the outputs in time");

        both_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
            (!i_async_preset_n[g] && !i_async_clear_n[g]) [*3] |=> (o_q[g] && o_q_b[g]))
            else $error("both control pins low did not drive both outputs high");
    end
endmodule : djkff_top
